// [flash_bus_assertions.sv]
// assertions on the flash bus between controller and device
`default_nettype none
module flash_bus_assertions (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic mode_reg_select_n,
	input wire logic [12:0] addr,
	input wire logic [15:0] dq,
	input wire logic ctl_dq_oe
);
	logic seen_q, cmd, act, rd, wr, mset, un;
	logic [12:0] row_q;
	logic [7:0] quiet_q;
	assign cmd = !cs_n && !(ras_n && cas_n && we_n);
	assign act = cmd && !ras_n && cas_n && mode_reg_select_n;
	assign rd = cmd && ras_n && !cas_n && we_n && mode_reg_select_n;
	assign wr = cmd && ras_n && !cas_n && !we_n;
	assign mset = cmd && !ras_n && !cas_n && !mode_reg_select_n;
	assign un = wr && row_q == flash_seq_pkg::ADDR_AA && addr[7:0] == 8'h55;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			seen_q <= 1'b0;
			row_q <= 13'h0000;
			quiet_q <= 8'h00;
		end else begin
			seen_q <= seen_q || mset;
			row_q <= act ? addr : row_q;
			// exit cycle itself is not counted, hence 99 quiet edges
			quiet_q <= un && dq[7:0] == flash_seq_pkg::DATA_EXIT ? 8'h63
				: quiet_q - 8'(quiet_q != 8'h00);
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_set; mset; endsequence
	sequence s_quiet; !cmd [*3]; endsequence
	a_mode_quiet: assert property (s_set |=> s_quiet)
		else $error("command too soon after mode set");
	a_mode_first: assert property (cmd && !seen_q |-> mset)
		else $error("command before mode set");
	a_row_gap: assert property (act |=> !act [*5])
		else $error("activations too close");
	a_stop_gap: assert property (rd |=> !(cmd && ras_n && cas_n))
		else $error("burst stop right after read");
	a_verify_gap: assert property (
		un && dq[7:0] == flash_seq_pkg::DATA_VERIFY |=> !rd)
		else $error("read too soon after verify");
	a_exit_quiet: assert property (quiet_q != 8'h00 |-> !cmd)
		else $error("command too soon after verify exit");
	a_unlock_data: assert property (
		wr && row_q == flash_seq_pkg::ADDR_55 && addr[7:0] == 8'h2a
		|-> dq[7:0] == flash_seq_pkg::DATA_55)
		else $error("wrong second unlock data");
	a_drive_write: assert property (ctl_dq_oe |-> wr)
		else $error("controller drives data outside a write");
endmodule : flash_bus_assertions
`default_nettype wire

// [flash_bus_if.sv]
// synchronous flash bus between the memory controller and the flash device
`default_nettype none
interface flash_bus_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic mode_reg_select_n;
	logic mr_high_volt;
	logic cke;
	logic dqm;
	logic [12:0] addr;
	logic [15:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [15:0] dev_dq_o;
	logic dev_dq_oe;
	logic [15:0] dq;
	// undriven bus reads as all ones, like a pulled-up line
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 16'hffff);
	modport dev(
		input cs_n, ras_n, cas_n, we_n, mode_reg_select_n, mr_high_volt,
		input cke, dqm, addr, dq,
		output dev_dq_o, dev_dq_oe
	);
	modport ctl(
		output cs_n, ras_n, cas_n, we_n, mode_reg_select_n, mr_high_volt,
		output cke, dqm, addr, ctl_dq_o, ctl_dq_oe,
		input dq, dev_dq_oe
	);
endinterface : flash_bus_if
`default_nettype wire

// [flash_ctl.sv]
// controller end: issues command sequences and reads into a two-entry buffer
`default_nettype none
module flash_ctl (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	flash_bus_if.ctl bus,
	input wire logic i_cmd_valid,
	input wire flash_seq_pkg::cmd_e i_cmd,
	input wire logic [12:0] i_row,
	input wire logic [7:0] i_col,
	input wire logic [15:0] i_wdata,
	input wire logic i_dqm,
	input wire logic i_hv_override,
	input wire logic i_power_down,
	input wire logic i_rd_ready,
	output logic o_cmd_ready,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data
);
	flash_seq_pkg::ctl_e st_q;
	flash_seq_pkg::cmd_e cmd_q;
	logic [12:0] row_q;
	logic [7:0] col_q;
	logic [15:0] wdata_q;
	logic [2:0] idx_q;
	logic [7:0] wait_q;
	logic [2:0] gap_q;
	logic ready_q;
	logic cs_n_q, ras_n_q, cas_n_q, we_n_q, mr_n_q, hv_q, dqm_q;
	logic [12:0] addr_q;
	logic [15:0] dq_q;
	logic dq_oe_q;
	logic cke_q, ck1_q, ck2_q;
	logic [15:0] head_q, tail_q;
	logic head_v_q, tail_v_q;
	logic push, pop, can;
	logic [1:0] occ_d;
	logic [3:0] rcnt_q;
	logic [28:0] cyc;
	logic last;

	function automatic logic [7:0] final_code(input flash_seq_pkg::cmd_e c);
		unique case (c)
			flash_seq_pkg::CMD_LOCKOUT: return flash_seq_pkg::DATA_LOCK;
			flash_seq_pkg::CMD_VERIFY: return flash_seq_pkg::DATA_VERIFY;
			flash_seq_pkg::CMD_VERIFY_EXIT: return flash_seq_pkg::DATA_EXIT;
			default: return flash_seq_pkg::DATA_CONT;
		endcase
	endfunction : final_code

	// one command bus cycle as {row, column, low data byte}
	always_comb begin
		unique case (idx_q)
			3'h0: cyc = {flash_seq_pkg::ADDR_AA, flash_seq_pkg::COL_55,
				flash_seq_pkg::DATA_AA};
			3'h1: cyc = {flash_seq_pkg::ADDR_55, flash_seq_pkg::COL_2A,
				flash_seq_pkg::DATA_55};
			3'h2: cyc = {flash_seq_pkg::ADDR_AA, flash_seq_pkg::COL_55,
				cmd_q == flash_seq_pkg::CMD_PROGRAM ? flash_seq_pkg::DATA_PROG
				: flash_seq_pkg::DATA_EXT};
			3'h3: cyc = (cmd_q == flash_seq_pkg::CMD_PROGRAM)
				? {row_q, col_q, wdata_q[7:0]}
				: {flash_seq_pkg::ADDR_AA, flash_seq_pkg::COL_55,
				flash_seq_pkg::DATA_AA};
			3'h4: cyc = (cmd_q == flash_seq_pkg::CMD_ERASE)
				? {flash_seq_pkg::ADDR_55, flash_seq_pkg::COL_2A,
				flash_seq_pkg::DATA_55}
				: {flash_seq_pkg::ADDR_AA, flash_seq_pkg::COL_55,
				final_code(cmd_q)};
			default: cyc = {row_q, 8'h00, flash_seq_pkg::DATA_ERASE};
		endcase
		last = (cmd_q == flash_seq_pkg::CMD_PROGRAM) ? (idx_q == 3'h3)
			: (cmd_q == flash_seq_pkg::CMD_ERASE) ? (idx_q == 3'h5)
			: (idx_q == 3'h4);
	end

	// commands only go out while the device is known to be clocking
	assign can = cke_q;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q <= flash_seq_pkg::C_MODE;
			cmd_q <= flash_seq_pkg::CMD_READ;
			row_q <= 13'h0000;
			col_q <= 8'h00;
			wdata_q <= 16'h0000;
			idx_q <= 3'h0;
			wait_q <= 8'h00;
			gap_q <= 3'h0;
			ready_q <= 1'b0;
			cs_n_q <= 1'b1;
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			we_n_q <= 1'b1;
			mr_n_q <= 1'b1;
			addr_q <= 13'h0000;
			dq_q <= 16'h0000;
			dq_oe_q <= 1'b0;
			rcnt_q <= 4'h0;
		end else begin
			// counts device edges that were not suspended since the read
			rcnt_q <= (ck1_q && rcnt_q != 4'hf) ? rcnt_q + 4'h1 : rcnt_q;
			cs_n_q <= 1'b1;
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			we_n_q <= 1'b1;
			mr_n_q <= 1'b1;
			dq_oe_q <= 1'b0;
			gap_q <= (gap_q == 3'h0) ? gap_q : gap_q - 3'h1;
			unique case (st_q)
				flash_seq_pkg::C_MODE: if (can) begin
					cs_n_q <= 1'b0;
					ras_n_q <= 1'b0;
					cas_n_q <= 1'b0;
					mr_n_q <= 1'b0;
					addr_q <= flash_seq_pkg::MODE_CODE;
					wait_q <= flash_seq_pkg::MRS_QUIET_CYCLES;
					st_q <= flash_seq_pkg::C_WAIT;
				end
				flash_seq_pkg::C_IDLE: if (i_cmd_valid && ready_q) begin
					ready_q <= 1'b0;
					cmd_q <= i_cmd;
					row_q <= i_row;
					col_q <= i_col;
					wdata_q <= i_wdata;
					idx_q <= 3'h0;
					st_q <= (i_cmd == flash_seq_pkg::CMD_MODE_SET)
						? flash_seq_pkg::C_MODE : flash_seq_pkg::C_ACT;
				end else if (i_power_down) begin
					ready_q <= 1'b0;
					st_q <= flash_seq_pkg::C_PD;
				end
				flash_seq_pkg::C_ACT: if (can && gap_q == 3'h0) begin
					cs_n_q <= 1'b0;
					ras_n_q <= 1'b0;
					addr_q <= (cmd_q == flash_seq_pkg::CMD_READ) ? row_q : cyc[28:16];
					gap_q <= flash_seq_pkg::ROW_GAP_CYCLES - 3'h1;
					wait_q <= flash_seq_pkg::RAS_LAT_WAIT;
					st_q <= (cmd_q == flash_seq_pkg::CMD_READ)
						? flash_seq_pkg::C_RD : flash_seq_pkg::C_WR;
				end
				flash_seq_pkg::C_WR: if (can) begin
					cs_n_q <= 1'b0;
					cas_n_q <= 1'b0;
					we_n_q <= 1'b0;
					addr_q <= {5'h00, cyc[15:8]};
					dq_q <= (cmd_q == flash_seq_pkg::CMD_PROGRAM && idx_q == 3'h3)
						? wdata_q : {8'h00, cyc[7:0]};
					dq_oe_q <= 1'b1;
					idx_q <= idx_q + 3'h1;
					if (last) begin
						wait_q <= (cmd_q == flash_seq_pkg::CMD_VERIFY)
							? flash_seq_pkg::VERIFY_READ_CYCLES
							: (cmd_q == flash_seq_pkg::CMD_VERIFY_EXIT)
							? flash_seq_pkg::EXIT_WAIT_CYCLES
							: flash_seq_pkg::CMD_GAP_WAIT;
						st_q <= flash_seq_pkg::C_WAIT;
					end else begin
						st_q <= flash_seq_pkg::C_ACT;
					end
				end
				flash_seq_pkg::C_RD: if (wait_q != 8'h00) begin
					wait_q <= wait_q - 8'h01;
				end else if (can) begin
					cs_n_q <= 1'b0;
					cas_n_q <= 1'b0;
					addr_q <= {5'h00, col_q};
					rcnt_q <= 4'h0;
					wait_q <= flash_seq_pkg::DRAIN_CYCLES;
					st_q <= flash_seq_pkg::C_DRAIN;
				end
				flash_seq_pkg::C_DRAIN: if (can) begin
					wait_q <= wait_q - 8'h01;
					if (wait_q == 8'h01) begin
						ready_q <= 1'b1;
						st_q <= flash_seq_pkg::C_IDLE;
					end
				end
				flash_seq_pkg::C_WAIT: begin
					wait_q <= wait_q - 8'h01;
					if (wait_q <= 8'h01) begin
						ready_q <= 1'b1;
						st_q <= flash_seq_pkg::C_IDLE;
					end
				end
				flash_seq_pkg::C_PD: if (!i_power_down) begin
					st_q <= flash_seq_pkg::C_PD_NOP;
				end
				flash_seq_pkg::C_PD_NOP: if (can) begin
					cs_n_q <= 1'b0;
					wait_q <= flash_seq_pkg::PD_EXIT_WAIT;
					st_q <= flash_seq_pkg::C_WAIT;
				end
				default: st_q <= flash_seq_pkg::C_IDLE;
			endcase
		end
	end

	// words reach the buffer three edges after the cke that let them out,
	// so cke is held low whenever those in flight could overfill it
	// the boot block also drives the bus while deselected, so only the
	// burst slots after the latency are taken
	assign push = (st_q == flash_seq_pkg::C_DRAIN) && ck2_q && bus.dev_dq_oe
		&& !tail_v_q && rcnt_q > {1'b0, flash_seq_pkg::MODE_CODE[2:0]}
		&& rcnt_q <= {1'b0, flash_seq_pkg::MODE_CODE[2:0]}
		+ flash_seq_pkg::BL4_WORDS;
	assign pop = head_v_q && i_rd_ready;
	always_comb begin
		occ_d = 2'({1'b0, head_v_q} + {1'b0, tail_v_q} + {1'b0, push}
			- {1'b0, pop});
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cke_q <= 1'b1;
			ck1_q <= 1'b1;
			ck2_q <= 1'b1;
			dqm_q <= 1'b0;
			hv_q <= 1'b0;
		end else begin
			cke_q <= (st_q != flash_seq_pkg::C_PD)
				&& ((st_q != flash_seq_pkg::C_DRAIN)
				|| ({1'b0, occ_d} + {2'h0, cke_q} + {2'h0, ck1_q} < 3'h2));
			ck1_q <= cke_q;
			ck2_q <= ck1_q;
			dqm_q <= i_dqm;
			hv_q <= i_hv_override;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			head_q <= 16'h0000;
			tail_q <= 16'h0000;
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
		end else begin
			unique case ({push, pop})
				2'b10: if (!head_v_q) begin
					head_q <= bus.dq;
					head_v_q <= 1'b1;
				end else begin
					tail_q <= bus.dq;
					tail_v_q <= 1'b1;
				end
				2'b01: if (tail_v_q) begin
					head_q <= tail_q;
					tail_v_q <= 1'b0;
				end else begin
					head_v_q <= 1'b0;
				end
				2'b11: if (tail_v_q) begin
					head_q <= tail_q;
					tail_q <= bus.dq;
				end else begin
					head_q <= bus.dq;
				end
				default: begin
				end
			endcase
		end
	end

	assign bus.cs_n = cs_n_q;
	assign bus.ras_n = ras_n_q;
	assign bus.cas_n = cas_n_q;
	assign bus.we_n = we_n_q;
	assign bus.mode_reg_select_n = mr_n_q;
	assign bus.mr_high_volt = hv_q;
	assign bus.cke = cke_q;
	assign bus.dqm = dqm_q;
	assign bus.addr = addr_q;
	assign bus.ctl_dq_o = dq_q;
	assign bus.ctl_dq_oe = dq_oe_q;
	assign o_cmd_ready = ready_q;
	assign o_rd_valid = head_v_q;
	assign o_rd_data = head_q;
endmodule : flash_ctl
`default_nettype wire

// [flash_dev.sv]
// flash device end: command sequencer, boot block, lockout and burst read
`default_nettype none
module flash_dev #(
	parameter logic [23:0] PROG_CYCLES = 24'h000010,
	parameter logic [23:0] ERASE_CYCLES = 24'h0061a8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	flash_bus_if.dev bus,
	input wire logic i_boot_auto,
	output logic o_boot_active,
	output logic o_locked,
	output logic o_busy,
	output logic o_verify_mode,
	output logic o_cont_test
);
	logic susp_q;
	logic init_q;
	logic boot_active_q;
	logic lock_q;
	logic verify_q;
	logic cont_q;
	logic [23:0] busy_cnt_q;
	logic [12:0] row_q;
	logic [2:0] cas_lat_q;
	logic bl8_q;
	flash_seq_pkg::seq_e seq_q;
	flash_seq_pkg::seq_e seq_d;
	logic [15:0] mem_q [flash_seq_pkg::BOOT_DEPTH];
	logic [2:0] rd_wait_q;
	logic [3:0] words_q;
	logic [12:0] raddr_q;
	logic pend_v_q;
	logic [7:0] pend_col_q;
	logic [3:0] since_rd_q;
	logic [2:0] stop_cnt_q;
	logic dqm_p1_q;
	logic dqm_p2_q;
	logic [15:0] out_q;
	logic out_oe_q;
	logic adv;
	logic take;
	logic is_mrs;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_stop;
	logic allow;
	logic prog_go;
	logic erase_go;
	logic lock_go;
	logic verify_go;
	logic exit_go;
	logic cont_go;
	logic prog_we;
	logic erase_boot;
	logic [7:0] wcol;
	logic [7:0] wdat;
	logic [12:0] prog_addr;
	logic [3:0] bl_words;
	logic [15:0] status_word;

	function automatic logic hit(input logic [12:0] r, input logic [7:0] c,
		input logic [7:0] d, input logic [12:0] er, input logic [7:0] ec,
		input logic [7:0] ed);
		return (r == er) && (c == ec) && (d == ed);
	endfunction : hit

	// a device frozen by cke still counts down its program and erase busy timer
	assign adv = !susp_q;
	assign take = adv && !bus.cs_n && (busy_cnt_q == 24'h000000);
	assign is_mrs = take && !bus.ras_n && !bus.cas_n && !bus.mode_reg_select_n;
	assign is_act = take && !bus.ras_n && bus.cas_n && bus.mode_reg_select_n;
	assign is_rd = take && bus.ras_n && !bus.cas_n && bus.mode_reg_select_n
		&& bus.we_n;
	assign is_wr = take && bus.ras_n && !bus.cas_n && !bus.we_n;
	assign is_stop = take && bus.ras_n && bus.cas_n && !bus.we_n
		&& bus.mode_reg_select_n;
	assign wcol = bus.addr[7:0];
	assign wdat = bus.dq[7:0];
	assign allow = boot_active_q && !(lock_q && !bus.mr_high_volt);
	assign prog_we = prog_go && allow;
	assign prog_addr = {row_q[4:0], wcol};
	assign erase_boot = erase_go && allow
		&& (row_q[flash_seq_pkg::SECTOR_MSB:flash_seq_pkg::SECTOR_LSB]
		== flash_seq_pkg::BOOT_SECTOR);
	assign bl_words = bl8_q ? flash_seq_pkg::BL8_WORDS : flash_seq_pkg::BL4_WORDS;
	assign status_word = {15'h0000, lock_q};

	always_comb begin
		seq_d = seq_q;
		prog_go = 1'b0;
		erase_go = 1'b0;
		lock_go = 1'b0;
		verify_go = 1'b0;
		exit_go = 1'b0;
		cont_go = 1'b0;
		if (is_wr) begin
			seq_d = flash_seq_pkg::SEQ_IDLE;
			unique case (seq_q)
				flash_seq_pkg::SEQ_IDLE: begin
					if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_AA,
						flash_seq_pkg::COL_55, flash_seq_pkg::DATA_AA)) begin
						seq_d = flash_seq_pkg::SEQ_C1;
					end
				end
				flash_seq_pkg::SEQ_C1: begin
					if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_55,
						flash_seq_pkg::COL_2A, flash_seq_pkg::DATA_55)) begin
						seq_d = flash_seq_pkg::SEQ_C2;
					end
				end
				flash_seq_pkg::SEQ_C2: begin
					if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_AA,
						flash_seq_pkg::COL_55, flash_seq_pkg::DATA_PROG)) begin
						seq_d = flash_seq_pkg::SEQ_PROG;
					end else if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_AA,
						flash_seq_pkg::COL_55, flash_seq_pkg::DATA_EXT)) begin
						seq_d = flash_seq_pkg::SEQ_X3;
					end
				end
				flash_seq_pkg::SEQ_PROG: begin
					prog_go = 1'b1;
				end
				flash_seq_pkg::SEQ_X3: begin
					if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_AA,
						flash_seq_pkg::COL_55, flash_seq_pkg::DATA_AA)) begin
						seq_d = flash_seq_pkg::SEQ_X4;
					end
				end
				flash_seq_pkg::SEQ_X4: begin
					if (row_q == flash_seq_pkg::ADDR_AA
						&& wcol == flash_seq_pkg::COL_55) begin
						lock_go = (wdat == flash_seq_pkg::DATA_LOCK);
						verify_go = (wdat == flash_seq_pkg::DATA_VERIFY);
						exit_go = (wdat == flash_seq_pkg::DATA_EXIT);
						cont_go = (wdat == flash_seq_pkg::DATA_CONT);
					end else if (hit(row_q, wcol, wdat, flash_seq_pkg::ADDR_55,
						flash_seq_pkg::COL_2A, flash_seq_pkg::DATA_55)) begin
						seq_d = flash_seq_pkg::SEQ_ERASE;
					end
				end
				flash_seq_pkg::SEQ_ERASE: begin
					erase_go = (wdat == flash_seq_pkg::DATA_ERASE);
				end
				default: begin
					seq_d = flash_seq_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			susp_q <= 1'b0;
		end else begin
			susp_q <= !bus.cke;
		end
	end

	// strap is caught on the first edge after reset release
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			init_q <= 1'b0;
			boot_active_q <= 1'b0;
			cas_lat_q <= flash_seq_pkg::CL_RESET;
			bl8_q <= 1'b0;
			row_q <= 13'h0000;
		end else begin
			init_q <= 1'b1;
			if (!init_q) begin
				boot_active_q <= i_boot_auto;
			end else if (is_mrs) begin
				boot_active_q <= boot_active_q
					| bus.addr[flash_seq_pkg::MODE_BOOT_BIT];
			end
			if (is_mrs) begin
				cas_lat_q <= bus.addr[flash_seq_pkg::MODE_CL_LSB +: 3];
				bl8_q <= bus.addr[flash_seq_pkg::MODE_BL8_BIT];
			end
			if (is_act) begin
				row_q <= bus.addr;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			seq_q <= flash_seq_pkg::SEQ_IDLE;
			lock_q <= 1'b0;
			verify_q <= 1'b0;
			cont_q <= 1'b0;
			busy_cnt_q <= 24'h000000;
		end else begin
			seq_q <= seq_d;
			if (lock_go && boot_active_q) begin
				lock_q <= 1'b1;
			end
			if (verify_go) begin
				verify_q <= 1'b1;
			end else if (exit_go) begin
				verify_q <= 1'b0;
			end
			if (cont_go) begin
				cont_q <= 1'b1;
			end
			if (prog_we) begin
				busy_cnt_q <= PROG_CYCLES;
			end else if (erase_go && (allow || !erase_boot)) begin
				busy_cnt_q <= ERASE_CYCLES;
			end else if (busy_cnt_q != 24'h000000) begin
				busy_cnt_q <= busy_cnt_q - 24'h000001;
			end
		end
	end

	// programming only clears bits; erase brings the whole block back to ones
	generate
		for (genvar g = 0; g < flash_seq_pkg::BOOT_DEPTH; g++) begin : g_word
			always_ff @(posedge i_clk_sys) begin
				if (erase_boot) begin
					mem_q[g] <= flash_seq_pkg::BOOT_ERASED;
				end else if (prog_we && prog_addr == 13'(g)) begin
					mem_q[g] <= mem_q[g] & bus.dq;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rd_wait_q <= 3'h0;
			words_q <= 4'h0;
			raddr_q <= 13'h0000;
			pend_v_q <= 1'b0;
			pend_col_q <= 8'h00;
			since_rd_q <= 4'h0;
			stop_cnt_q <= 3'h0;
			dqm_p1_q <= 1'b0;
			dqm_p2_q <= 1'b0;
			out_q <= 16'h0000;
			out_oe_q <= 1'b0;
		end else if (adv) begin
			dqm_p1_q <= bus.dqm;
			dqm_p2_q <= dqm_p1_q;
			since_rd_q <= is_rd ? 4'h0
				: (since_rd_q == 4'hf ? since_rd_q : since_rd_q + 4'h1);
			if (is_stop) begin
				stop_cnt_q <= cas_lat_q;
			end else if (stop_cnt_q != 3'h0) begin
				stop_cnt_q <= stop_cnt_q - 3'h1;
			end
			if (stop_cnt_q == 3'h1) begin
				words_q <= 4'h0;
				pend_v_q <= 1'b0;
				out_oe_q <= 1'b0;
			end else if (is_rd && words_q != 4'h0
				&& since_rd_q >= flash_seq_pkg::COL_TO_COL_MIN) begin
				pend_v_q <= 1'b1;
				pend_col_q <= wcol;
			end else if (is_rd) begin
				rd_wait_q <= cas_lat_q - 3'h1;
				words_q <= bl_words;
				raddr_q <= {row_q[4:0], wcol};
				pend_v_q <= 1'b0;
			end else if (rd_wait_q != 3'h0) begin
				rd_wait_q <= rd_wait_q - 3'h1;
			end else if (words_q != 4'h0) begin
				out_q <= verify_q ? status_word : mem_q[raddr_q];
				out_oe_q <= !dqm_p2_q;
				raddr_q <= raddr_q + 13'h0001;
				words_q <= words_q - 4'h1;
				if (words_q == 4'h1 && pend_v_q) begin
					rd_wait_q <= cas_lat_q - 3'h1;
					words_q <= bl_words;
					raddr_q <= {row_q[4:0], pend_col_q};
					pend_v_q <= 1'b0;
				end
			end else begin
				out_oe_q <= 1'b0;
			end
		end
	end

	// boot block output runs straight from the address pins, no clock
	assign bus.dev_dq_o = out_oe_q ? out_q : mem_q[bus.addr];
	assign bus.dev_dq_oe = out_oe_q
		|| (boot_active_q && bus.cs_n && !verify_q && !cont_q);
	assign o_boot_active = boot_active_q;
	assign o_locked = lock_q;
	assign o_busy = (busy_cnt_q != 24'h000000);
	assign o_verify_mode = verify_q;
	assign o_cont_test = cont_q;
endmodule : flash_dev
`default_nettype wire

// [flash_seq_pkg.sv]
// constants, types and command codes shared by both ends of the flash bus
// Contract
// - boot block is 8K words, 13-bit address, 16-bit data
// - active boot block output follows address without clock
// - strap variant auto-enables boot block; else mode set
// - boot block program and erase use bus cycles, 16-bit
// - lockout refuses every boot block program and erase
// - lockout command: five cycles, prefix, 80, then 40
// - verify read gives 00 modifiable or 01 locked
// - controller waits 200 ns after verify before read
// - exit code F0 restores; controller then waits 10 us
// - high-voltage override suspends lockout while present
// - only low data byte decoded; program is four cycles
// - erase six cycles code 30; test 70; verify 90
// - three quiet deselected cycles after mode set
// - controller does mode set first after reset
// - DQM masks output two clocks later, one cycle
// - CKE low freezes device from next clock on
// - burst stop releases bus after CAS latency
// - at least one cycle from read to burst stop
// - after power-down exit, NOP then one more clock
// - late second column read waits for first burst
// - row activations at least six cycles apart
// - read is CS and CAS low, mode select high
// - commands are discarded while erase or program runs
`default_nettype none
package flash_seq_pkg;
	localparam int ROW_W = 13;
	localparam int COL_W = 8;
	localparam int DQ_W = 16;
	localparam int BOOT_AW = 13;
	localparam int BOOT_DEPTH = 8192;
	localparam logic [15:0] BOOT_ERASED = 16'hffff;
	localparam logic [2:0] BOOT_SECTOR = 3'h0;
	localparam int SECTOR_MSB = 12;
	localparam int SECTOR_LSB = 10;
	localparam logic [12:0] ADDR_AA = 13'h00aa;
	localparam logic [12:0] ADDR_55 = 13'h0055;
	localparam logic [7:0] COL_55 = 8'h55;
	localparam logic [7:0] COL_2A = 8'h2a;
	localparam logic [7:0] DATA_AA = 8'haa;
	localparam logic [7:0] DATA_55 = 8'h55;
	localparam logic [7:0] DATA_PROG = 8'ha0;
	localparam logic [7:0] DATA_EXT = 8'h80;
	localparam logic [7:0] DATA_LOCK = 8'h40;
	localparam logic [7:0] DATA_VERIFY = 8'h90;
	localparam logic [7:0] DATA_EXIT = 8'hf0;
	localparam logic [7:0] DATA_CONT = 8'h70;
	localparam logic [7:0] DATA_ERASE = 8'h30;
	localparam int MODE_CL_LSB = 0;
	localparam int MODE_BL8_BIT = 3;
	localparam int MODE_BOOT_BIT = 4;
	localparam logic [2:0] CL_RESET = 3'h5;
	localparam logic [12:0] MODE_CODE = 13'h0015;
	localparam logic [3:0] BL4_WORDS = 4'h4;
	localparam logic [3:0] BL8_WORDS = 4'h8;
	localparam logic [3:0] COL_TO_COL_MIN = 4'h4;
	localparam int CLK_PERIOD_NS = 100;
	localparam int VERIFY_READ_NS = 200;
	localparam int EXIT_WAIT_US = 10;
	localparam logic [7:0] VERIFY_READ_CYCLES =
		8'((VERIFY_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] EXIT_WAIT_CYCLES =
		8'((EXIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MRS_QUIET_CYCLES = 8'h03;
	localparam logic [7:0] RAS_LAT_WAIT = 8'h01;
	localparam logic [7:0] PD_EXIT_WAIT = 8'h01;
	localparam logic [7:0] CMD_GAP_WAIT = 8'h01;
	localparam logic [2:0] ROW_GAP_CYCLES = 3'h6;
	localparam logic [7:0] DRAIN_CYCLES = 8'h14;
	typedef enum logic [2:0] {
		CMD_PROGRAM, CMD_ERASE, CMD_LOCKOUT, CMD_VERIFY,
		CMD_VERIFY_EXIT, CMD_CONT_TEST, CMD_READ, CMD_MODE_SET
	} cmd_e;
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_C1, SEQ_C2, SEQ_PROG, SEQ_X3, SEQ_X4, SEQ_ERASE
	} seq_e;
	typedef enum logic [3:0] {
		C_MODE, C_IDLE, C_ACT, C_WR, C_RD, C_DRAIN, C_WAIT, C_PD, C_PD_NOP
	} ctl_e;
endpackage : flash_seq_pkg
`default_nettype wire

// [test_sync_flash_boot_block_command_seq.sv]
// self-checking bench for the flash controller and device pair
`default_nettype none
module test_sync_flash_boot_block_command_seq;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys, i_rst, i_boot_auto, i_cmd_valid, i_dqm, i_hv_override;
	logic i_power_down, i_rd_ready, o_cmd_ready, o_rd_valid, o_boot_active;
	logic o_locked, o_busy, o_verify_mode, o_cont_test;
	flash_seq_pkg::cmd_e i_cmd;
	logic [12:0] i_row, r;
	logic [7:0] i_col;
	logic [15:0] i_wdata, o_rd_data, d, d2;
	logic [31:0] seed;
	int error_cnt, samples_checked;
	flash_bus_if bus();
	flash_dev #(.PROG_CYCLES(24'h000008), .ERASE_CYCLES(24'h000014))
		flash_dev_i (.i_clk_sys, .i_rst, .bus, .i_boot_auto, .o_boot_active,
		.o_locked, .o_busy, .o_verify_mode, .o_cont_test);
	flash_ctl flash_ctl_i (.i_clk_sys, .i_rst, .bus, .i_cmd_valid, .i_cmd,
		.i_row, .i_col, .i_wdata, .i_dqm, .i_hv_override, .i_power_down,
		.i_rd_ready, .o_cmd_ready, .o_rd_valid, .o_rd_data);
	flash_bus_assertions flash_bus_assertions_i (.i_clk_sys, .i_rst,
		.cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
		.we_n(bus.we_n), .mode_reg_select_n(bus.mode_reg_select_n),
		.addr(bus.addr), .dq(bus.dq), .ctl_dq_oe(bus.ctl_dq_oe));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// programming only clears bits
	function automatic logic [15:0] prog_exp(input logic [15:0] o, n);
		return o & n;
	endfunction : prog_exp
	task automatic check(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic results();
		$display("mismatches %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic wait_ready();
		for (int n = 0; !(o_cmd_ready === 1'b1 && o_busy === 1'b0); n++) begin
			if (n > 3000) begin
				error_cnt++;
				results();
			end
			@(negedge i_clk_sys);
		end
	endtask : wait_ready
	task automatic issue(input flash_seq_pkg::cmd_e k, input logic [12:0] a,
		input logic [15:0] v);
		wait_ready();
		i_cmd = k;
		{i_row, i_wdata} = {a, v};
		i_cmd_valid = 1'b1;
		@(negedge i_clk_sys);
		i_cmd_valid = 1'b0;
	endtask : issue
	task automatic read_chk(input logic [15:0] e0, e1);
		int k;
		k = 0;
		issue(flash_seq_pkg::CMD_READ, r, 16'h0000);
		for (int n = 0; n < 300 && k < 4; n++) begin
			seed = xs(seed);
			// random stalls fill the two-entry buffer and throttle the burst
			i_rd_ready = o_rd_valid === 1'b1 && seed[0];
			if (i_rd_ready) begin
				check(o_rd_data, k == 0 ? e0 : e1);
				k++;
			end
			@(negedge i_clk_sys);
		end
		i_rd_ready = 1'b0;
		check(16'(k), 16'h0004);
	endtask : read_chk
	task automatic verify(input logic lk);
		issue(flash_seq_pkg::CMD_VERIFY, r, 16'h0000);
		read_chk({15'h0000, lk}, {15'h0000, lk});
		issue(flash_seq_pkg::CMD_VERIFY_EXIT, r, 16'h0000);
		wait_ready();
		check({15'h0000, o_verify_mode}, 16'h0000);
	endtask : verify
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		{i_boot_auto, i_cmd_valid, i_dqm, i_hv_override} = 4'h0;
		{i_power_down, i_rd_ready, error_cnt, samples_checked} = 66'h0;
		i_cmd = flash_seq_pkg::CMD_READ;
		{i_row, i_col, i_wdata} = 37'h0;
		seed = xs(32'h0000f5ab);
		i_rst = 1'b1;
		repeat (20) @(negedge i_clk_sys);
		i_rst = 1'b0;
		@(negedge i_clk_sys);
		// without the strap the block waits for the mode set
		check({15'h0000, o_boot_active}, 16'h0000);
		// boot sector row, four-word-aligned column keeps the burst in erased words
		{r, i_col, d} = {8'h00, seed[4:0], seed[13:8], 2'h0, seed[31:16]};
		seed = xs(seed);
		d2 = seed[15:0];
		wait_ready();
		check({15'h0000, o_boot_active}, 16'h0001);
		issue(flash_seq_pkg::CMD_ERASE, r, 16'h0000);
		read_chk(16'hffff, 16'hffff);
		verify(1'b0);
		issue(flash_seq_pkg::CMD_PROGRAM, r, d);
		read_chk(prog_exp(16'hffff, d), 16'hffff);
		issue(flash_seq_pkg::CMD_ERASE, 13'h0400, 16'h0000);
		read_chk(prog_exp(16'hffff, d), 16'hffff);
		issue(flash_seq_pkg::CMD_LOCKOUT, r, 16'h0000);
		wait_ready();
		check({15'h0000, o_locked}, 16'h0001);
		verify(1'b1);
		issue(flash_seq_pkg::CMD_PROGRAM, r, d2);
		issue(flash_seq_pkg::CMD_ERASE, r, 16'h0000);
		read_chk(prog_exp(16'hffff, d), 16'hffff);
		i_hv_override = 1'b1;
		issue(flash_seq_pkg::CMD_PROGRAM, r, d2);
		wait_ready();
		i_hv_override = 1'b0;
		read_chk(prog_exp(d, d2), 16'hffff);
		wait_ready();
		i_power_down = 1'b1;
		repeat (6) @(negedge i_clk_sys);
		check({15'h0000, o_cmd_ready}, 16'h0000);
		i_power_down = 1'b0;
		issue(flash_seq_pkg::CMD_CONT_TEST, r, 16'h0000);
		wait_ready();
		check({15'h0000, o_cont_test}, 16'h0001);
		// strapped variant is active one edge after reset, before any mode set
		i_boot_auto = 1'b1;
		i_rst = 1'b1;
		@(negedge i_clk_sys);
		i_rst = 1'b0;
		@(negedge i_clk_sys);
		check({15'h0000, o_boot_active}, 16'h0001);
		results();
	end
endmodule : test_sync_flash_boot_block_command_seq
`default_nettype wire
